// ==== design/omt_delay.sv ====
/*
  Holds an output until its input has differed for N cycles.
  Assumes a synchronised input on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module omt_delay #(
  parameter int unsigned N = 1
) (
  input wire logic clk, // Reference clock
  input wire logic rst_n, // Async reset, low
  input wire logic clr, // Forces output low
  input wire logic d, // Condition in
  output logic q // Settled condition
);
  localparam int CW = $clog2(N + 1); // Counter width
  logic [CW-1:0] cnt_q; // Cycles of difference

  // Count while input differs, follow at N
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      q <= 1'b0;
    end else if (clr || (d == q)) begin
      cnt_q <= '0;
      q <= q & ~clr;
    end else if (cnt_q == CW'(N - 1)) begin
      cnt_q <= '0;
      q <= d;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Output moves only at the full count or on clear
  chk_delay_bound: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(q) |-> ($past(cnt_q) == CW'(N - 1)) || $past(clr))
    else $error("delay output moved early");
endmodule
`default_nettype wire

// ==== design/omt_pkg.sv ====
/*
  Constants, map and carrier types of the module management block.
  Assumes a 25 MHz reference clock and a fast link oversampling clock.
*/
package omt_pkg;
  localparam int LANES = 4; // Lanes per direction
  localparam int REF_KHZ = 25000; // Reference clock rate
  localparam int T_INIT_MS = 2000; // Init, reset and serial ready limit
  localparam int T_RST_MIN_US = 2; // Shortest reset pulse
  localparam int T_RXSQ_US = 80; // Rx squelch limit
  localparam int T_TXSQ_MS = 400; // Tx squelch limit
  localparam int SYNC_LAT = 4; // Sync plus output flop margin
  localparam int unsigned INIT_CYC = T_INIT_MS * REF_KHZ; // Longest, round down
  localparam int RST_MIN_CYC = (T_RST_MIN_US * REF_KHZ + 999) / 1000; // Least, round up
  localparam int RXSQ_CYC = T_RXSQ_US * REF_KHZ / 1000 - SYNC_LAT; // Rx squelch delay
  localparam int unsigned TXSQ_CYC = T_TXSQ_MS * REF_KHZ - SYNC_LAT; // Tx squelch delay
  localparam logic [6:0] DEV_ADDR = 7'h50; // Bus address A0h
  localparam logic [3:0] BYTE_BITS = 4'h8; // Bits per byte
  localparam logic [7:0] A_STATUS = 8'h02; // Not-ready and interrupt level
  localparam logic [7:0] A_LOS = 8'h03; // Rx and tx loss latches
  localparam logic [7:0] A_FAULT = 8'h04; // Tx fault latches
  localparam logic [7:0] A_TXDIS = 8'h56; // Tx disable per lane
  localparam logic [7:0] A_PWR = 8'h5D; // Power control
  localparam logic [7:0] A_MASK_LOS = 8'h64; // Loss masks
  localparam logic [7:0] A_MASK_FLT = 8'h65; // Fault masks
  localparam logic [7:0] A_PAGE = 8'h7F; // Upper page select
  localparam logic [7:0] A_SQDIS = 8'hF0; // Squelch disables, control page
  localparam logic [7:0] A_RXDIS = 8'hF1; // Rx disables, control page
  localparam logic [7:0] CTL_PAGE = 8'h03; // Page holding lane controls
  localparam int NRDY_BIT = 0; // Monitor not ready
  localparam int IRQ_BIT = 1; // Soft interrupt level
  localparam int PD_BIT = 1; // Soft power down
  localparam int RXDIS_LSB = 4; // Rx disable field base
  localparam logic [14:0] SYNC_RST = 15'h2000; // Reset pin idles high
  localparam logic [2:0] SYN_IDLE = 3'h7; // Select, clock, data idle high

  // One byte access handed from link to reference domain
  typedef struct packed {
    logic we; // Write when set
    logic [7:0] addr; // Byte address
    logic [7:0] wdata; // Write data
  } omt_acc_s;
endpackage

// ==== design/omt_top.sv ====
/*
  Management and status response logic of a four lane optical module.
  Assumes pins arrive asynchronously and a link clock oversamples the bus.
*/
// Function
// - Fully functional within 2000 ms of start
// - Low power pin: power level 1, 100 us
// - Interrupt low within 200 ms of cause
// - Interrupt released within 500 us after read
// - Reset only on low longer than 2 us
// - Functional within 2000 ms after reset rise
// - Serial answers within 2000 ms of power-on
// - Not-ready cleared, interrupt raised within 2000 ms
// - Rx loss flag and interrupt within 100 ms
// - Tx fault flag and interrupt within 200 ms
// - Other flags and interrupt within 200 ms
// - Set mask stops interrupt within 100 ms
// - Cleared mask restores interrupt within 100 ms
// - Power down bit: level 1 within 100 ms
// - Power down cleared: functional within 300 ms
// - Rx squelch follows input loss, 80 us
// - Tx squelch follows input loss, 400 ms
// - Tx disable: off 100 ms, on 400 ms
// - Rx disable: off and on within 100 ms
// - Squelch disable acts within 100 ms
// - Lower page plus selectable 128 byte pages
// - Single bus address A0h for all pages
// - Ignore bus while module select high
// - Status flags latch, clear on read
// - Reset completion: interrupt with not-ready negated
`timescale 1ns/1ps
`default_nettype none
module omt_top import omt_pkg::*; #(
  parameter int unsigned INIT_CYC_P = INIT_CYC, // Start-up time in cycles
  parameter int unsigned TXSQ_CYC_P = TXSQ_CYC, // Tx squelch delay
  parameter int UP_PAGES = 4 // Upper pages held
) (
  input wire logic REF_CLK, // Management clock
  input wire logic RESETN, // Power-on reset, low
  input wire logic LINK_CLK, // Bus oversampling clock
  input wire logic SCL, // Serial clock pin
  input wire logic SDA_I, // Serial data in
  output logic SDA_O, // Serial data out level
  output logic SDA_OE, // Serial data drive
  input wire logic MODULE_SELECT_N, // Bus select, low
  input wire logic RESET_IN_N, // Reset pin, low
  input wire logic LOW_POWER_PIN, // Low power request
  input wire logic [LANES-1:0] RX_LOS_IN, // Rx signal lost
  input wire logic [LANES-1:0] TX_LOS_IN, // Tx signal lost
  input wire logic [LANES-1:0] TX_FAULT_IN, // Tx fault
  output logic INTERRUPT_OUT_O, // Interrupt low level
  output logic INTERRUPT_OUT_OE, // Interrupt drive
  output logic POWER_LOW, // Power level 1
  output logic MOD_READY, // Fully functional
  output logic [LANES-1:0] TX_EN, // Tx optical enable
  output logic [LANES-1:0] RX_EN // Rx output enable
);
  localparam int UPW = $clog2(UP_PAGES); // Page index width
  localparam int RCW = $clog2(RST_MIN_CYC + 1); // Reset filter width

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  // Link domain slave
  omt_acc_s acc; // Held request
  logic req_t, ack_t_q; // Handshake toggles
  logic [7:0] rdata_q; // Read answer
  logic od_lo_q; // Open drain low level

  omt_tws_slave u_tws (
    .clk(LINK_CLK),
    .rst_n(RESETN),
    .scl_i(SCL),
    .sda_i(SDA_I),
    .sel_n_i(MODULE_SELECT_N),
    .ack_t_i(ack_t_q),
    .rdata_i(rdata_q),
    .sda_o(SDA_O),
    .sda_oe(SDA_OE),
    .req_t_o(req_t),
    .acc_o(acc)
  );

  // Pin and toggle synchroniser
  logic [14:0] syn1_q, syn2_q; // {req, rst_n, lp, fault, txlos, rxlos}
  logic req_p_q; // Last request toggle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      syn1_q <= SYNC_RST;
      syn2_q <= SYNC_RST;
      req_p_q <= 1'b0;
    end else begin
      syn1_q <= {req_t, RESET_IN_N, LOW_POWER_PIN, TX_FAULT_IN, TX_LOS_IN, RX_LOS_IN};
      syn2_q <= syn1_q;
      req_p_q <= syn2_q[14];
    end
  end

  wire rst_pin_n = syn2_q[13]; // Settled reset pin
  wire lp_s = syn2_q[12]; // Settled low power pin
  wire [11:0] cond = syn2_q[11:0]; // {fault, txlos, rxlos}
  wire [LANES-1:0] rx_los_s = cond[3:0]; // Rx loss per lane
  wire [LANES-1:0] tx_los_s = cond[7:4]; // Tx loss per lane
  wire [LANES-1:0] flt_s = cond[11:8]; // Tx fault per lane
  wire acc_go = syn2_q[14] ^ req_p_q; // New access
  wire [7:0] a = acc.addr; // Access address

  // Reset pin filter
  logic [RCW-1:0] rst_cnt_q; // Low time count
  logic rst_held_q; // Module held in reset
  wire mod_rst = rst_held_q; // Module state reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_cnt_q <= '0;
      rst_held_q <= 1'b0;
    end else if (rst_pin_n) begin
      rst_cnt_q <= '0;
      rst_held_q <= 1'b0;
    end else if (rst_cnt_q != RCW'(RST_MIN_CYC)) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end else begin
      rst_held_q <= 1'b1;
    end
  end

  // Initialisation timer, restarts on reset release
  logic [31:0] init_cnt_q; // Init cycles
  logic ready_q; // Fully functional
  logic init_flag_q; // Completion interrupt latch
  wire init_done = !ready_q && (init_cnt_q == INIT_CYC_P - 1);
  wire clr_st = acc_go && !acc.we && (a == A_STATUS); // Status read
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      init_cnt_q <= '0;
      ready_q <= 1'b0;
      init_flag_q <= 1'b0;
    end else if (mod_rst) begin
      init_cnt_q <= '0;
      ready_q <= 1'b0;
      init_flag_q <= 1'b0;
    end else begin
      init_cnt_q <= init_done ? init_cnt_q : init_cnt_q + 1'b1;
      ready_q <= ready_q | init_done;
      init_flag_q <= init_done | (init_flag_q & ~clr_st);
    end
  end

  // Register writes and read clears
  wire wr = acc_go & acc.we; // Write strobe
  wire rd = acc_go & ~acc.we; // Read strobe
  wire [11:0] clr_lat = {{4{rd && (a == A_FAULT)}}, {8{rd && (a == A_LOS)}}}; // Clear on read
  logic [11:0] lat_q, mask_q; // Flag latches and masks
  logic [LANES-1:0] txdis_q, rxdis_q, flt_hold_q; // Lane controls
  logic [7:0] sqdis_q, page_q; // Squelch disables, page
  logic pdown_q; // Soft power down
  wire ctl_pg = (page_q == CTL_PAGE); // Lane control page visible

  // Latches: a new condition wins over the read clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lat_q <= '0;
      flt_hold_q <= '0;
    end else if (mod_rst) begin
      lat_q <= '0;
      flt_hold_q <= '0;
    end else begin
      lat_q <= (lat_q & ~clr_lat) | cond;
      flt_hold_q <= flt_s | (flt_hold_q & ~(wr && (a == A_TXDIS) ? ~acc.wdata[3:0] & txdis_q : '0));
    end
  end

  // Control bytes, defaults after any reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      {mask_q, txdis_q, rxdis_q, sqdis_q, page_q, pdown_q} <= '0;
    end else if (mod_rst) begin
      {mask_q, txdis_q, rxdis_q, sqdis_q, page_q, pdown_q} <= '0;
    end else if (wr) begin
      if (a == A_TXDIS) txdis_q <= acc.wdata[3:0];
      if (a == A_PWR) pdown_q <= acc.wdata[PD_BIT];
      if (a == A_MASK_LOS) mask_q[7:0] <= acc.wdata;
      if (a == A_MASK_FLT) mask_q[11:8] <= acc.wdata[3:0];
      if (a == A_PAGE) page_q <= acc.wdata;
      if (ctl_pg && (a == A_SQDIS)) sqdis_q <= acc.wdata;
      if (ctl_pg && (a == A_RXDIS)) rxdis_q <= acc.wdata[RXDIS_LSB +: LANES];
    end
  end

  // Upper page storage
  logic [7:0] up_mem [UP_PAGES*128]; // Selectable upper pages
  wire [UPW+6:0] up_idx = {page_q[UPW-1:0], a[6:0]}; // Page and offset
  wire up_ok = a[7] && (page_q < 8'(UP_PAGES)) && !(ctl_pg && (a == A_SQDIS || a == A_RXDIS));
  always_ff @(posedge REF_CLK) begin
    if (wr && up_ok) begin
      up_mem[up_idx] <= acc.wdata;
    end
  end

  // Read selection
  // Invert on single bits first, so widening cannot fill ones
  wire nrdy = ~ready_q; // Monitor not ready
  wire irq_lvl = ~INTERRUPT_OUT_OE; // Pin level, high when idle
  wire [7:0] st_byte = (8'(nrdy) << NRDY_BIT) | (8'(irq_lvl) << IRQ_BIT);
  wire [7:0] rd_byte =
    up_ok ? up_mem[up_idx] :
    (a == A_STATUS) ? st_byte :
    (a == A_LOS) ? lat_q[7:0] :
    (a == A_FAULT) ? {4'h0, lat_q[11:8]} :
    (a == A_TXDIS) ? {4'h0, txdis_q} :
    (a == A_PWR) ? 8'(32'(pdown_q) << PD_BIT) :
    (a == A_MASK_LOS) ? mask_q[7:0] :
    (a == A_MASK_FLT) ? {4'h0, mask_q[11:8]} :
    (a == A_PAGE) ? page_q :
    (ctl_pg && a == A_SQDIS) ? sqdis_q :
    (ctl_pg && a == A_RXDIS) ? 8'({rxdis_q, 4'h0}) : 8'h00;

  // Answer and done toggle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
      ack_t_q <= 1'b0;
    end else if (acc_go) begin
      rdata_q <= rd_byte;
      ack_t_q <= ~ack_t_q;
    end
  end

  // Squelch timers per lane
  wire [LANES-1:0] rx_sq, tx_sq; // Settled loss per lane
  for (genvar l = 0; l < LANES; l++) begin : g_sq
    omt_delay #(.N(RXSQ_CYC)) u_rxsq (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .clr(mod_rst),
      .d(rx_los_s[l]),
      .q(rx_sq[l])
    );
    omt_delay #(.N(TXSQ_CYC_P)) u_txsq (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .clr(mod_rst),
      .d(tx_los_s[l]),
      .q(tx_sq[l])
    );
  end

  // Interrupt and lane outputs
  wire [11:0] live = lat_q & ~mask_q;
  wire irq_pend = (|live) | init_flag_q;
  wire [LANES-1:0] rx_sq_on = rx_sq & ~sqdis_q[7:4];
  wire [LANES-1:0] tx_sq_on = tx_sq & ~sqdis_q[3:0];
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      {od_lo_q, INTERRUPT_OUT_OE, POWER_LOW, MOD_READY} <= '0;
      TX_EN <= '0;
      RX_EN <= '0;
    end else begin
      od_lo_q <= 1'b0;
      INTERRUPT_OUT_OE <= irq_pend;
      POWER_LOW <= lp_s | pdown_q;
      MOD_READY <= ready_q;
      TX_EN <= {LANES{ready_q}} & ~txdis_q & ~flt_hold_q & ~tx_sq_on;
      RX_EN <= {LANES{ready_q}} & ~rxdis_q & ~rx_sq_on;
    end
  end
  assign INTERRUPT_OUT_O = od_lo_q;

  // Unmasked flag raises interrupt next cycle
  chk_irq_assert: assert property (|live |=> INTERRUPT_OUT_OE)
    else $error("interrupt late");
  // No pending cause releases it next cycle
  chk_irq_release: assert property (!irq_pend |=> !INTERRUPT_OUT_OE)
    else $error("interrupt not released");
  // Conditions land in latches next cycle
  chk_flag_latch: assert property (!mod_rst |=> ((lat_q & $past(cond)) == $past(cond)))
    else $error("flag not latched");
  // Latched but masked flags hold interrupt off
  chk_mask_gate: assert property (((lat_q & mask_q) != '0) && (live == '0) && !init_flag_q |=> !INTERRUPT_OUT_OE)
    else $error("masked flag leaked");
  // Completion steps: ready and latch, then the pin
  sequence s_post;
    ready_q && init_flag_q ##1 INTERRUPT_OUT_OE;
  endsequence
  // Completion posts interrupt with not-ready negated
  chk_init_post: assert property (init_done |=> s_post)
    else $error("completion not posted");
  // Power down or pin gives power level 1
  chk_power_low: assert property ((lp_s || pdown_q) |=> POWER_LOW)
    else $error("power level not reduced");
  // Held reset rises only if the reset pin was low two cycles before
  chk_rst_filter: assert property ($rose(rst_held_q) |-> $past(!rst_pin_n, 2))
    else $error("reset taken on short pulse");
  // Held reset drops readiness
  chk_rst_ready: assert property (rst_held_q |=> !ready_q ##1 !MOD_READY)
    else $error("ready during reset");
  // Disabled lanes are dark one cycle later
  chk_tx_dis: assert property (1'b1 |=> (($past(txdis_q) & TX_EN) == '0))
    else $error("tx lane lit while disabled");
  chk_rx_dis: assert property (1'b1 |=> (($past(rxdis_q) & RX_EN) == '0))
    else $error("rx lane on while disabled");
endmodule
`default_nettype wire

// ==== design/omt_tws_slave.sv ====
/*
  Two-wire serial slave on the oversampling link clock.
  Assumes bus clock far slower than link clock and a host that waits.
*/
`timescale 1ns/1ps
`default_nettype none
module omt_tws_slave import omt_pkg::*; (
  input wire logic clk, // Link clock
  input wire logic rst_n, // Async reset, low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin
  input wire logic sel_n_i, // Module select pin
  input wire logic ack_t_i, // Done toggle from reference side
  input wire logic [7:0] rdata_i, // Read byte, stable after done
  output logic sda_o, // Data low level
  output logic sda_oe, // Pulls data low
  output logic req_t_o, // Request toggle
  output omt_acc_s acc_o // Request contents
);
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_ADDR, S_WR, S_ACK, S_RD, S_RACK} omt_st_e;
  omt_st_e state_q, nxt_q; // State, state after ack
  logic [2:0] syn1_q, syn2_q; // Pin synchroniser {sel_n, scl, sda}
  logic scl_p_q, sda_p_q; // Previous settled levels
  logic ack1_q, ack2_q, ack3_q; // Done toggle synchroniser
  logic [7:0] sh_q, ptr_q, rbuf_q; // Shifter, pointer, read buffer
  logic [3:0] cnt_q; // Bit count

  wire scl_s = syn2_q[1]; // Settled clock
  wire sda_s = syn2_q[0]; // Settled data
  wire sel = ~syn2_q[2]; // Module selected
  wire rise = scl_s & ~scl_p_q; // Clock rising
  wire fall = ~scl_s & scl_p_q; // Clock falling
  wire start = scl_s & scl_p_q & sda_p_q & ~sda_s; // Start condition
  wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s; // Stop condition
  wire ack_ev = ack2_q ^ ack3_q; // Read data arrived
  wire byte_end = fall && (cnt_q == BYTE_BITS); // Eighth bit done

  // Synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syn1_q <= SYN_IDLE;
      syn2_q <= SYN_IDLE;
      {scl_p_q, sda_p_q} <= 2'h3;
      {ack1_q, ack2_q, ack3_q} <= 3'h0;
    end else begin
      syn1_q <= {sel_n_i, scl_i, sda_i};
      syn2_q <= syn1_q;
      {scl_p_q, sda_p_q} <= syn2_q[1:0];
      {ack1_q, ack2_q, ack3_q} <= {ack_t_i, ack1_q, ack2_q};
    end
  end

  // Byte engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      nxt_q <= S_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rbuf_q <= 8'h00;
      cnt_q <= 4'h0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      req_t_o <= 1'b0;
      acc_o <= '0;
    end else begin
      if (ack_ev) begin
        rbuf_q <= rdata_i;
      end
      if (!sel || stop) begin
        state_q <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (start) begin
        state_q <= S_DEV;
        cnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        unique case (state_q)
          S_IDLE: begin
            cnt_q <= 4'h0;
          end
          S_DEV, S_ADDR, S_WR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 1'b1;
            end else if (byte_end) begin
              sda_oe <= 1'b1;
              state_q <= S_ACK;
              nxt_q <= S_WR;
              if (state_q == S_DEV) begin
                nxt_q <= sh_q[0] ? S_RD : S_ADDR;
                if (sh_q[7:1] != DEV_ADDR) begin
                  sda_oe <= 1'b0;
                  state_q <= S_IDLE;
                end else if (sh_q[0]) begin
                  acc_o <= '{we: 1'b0, addr: ptr_q, wdata: 8'h00};
                  req_t_o <= ~req_t_o;
                end
              end else if (state_q == S_ADDR) begin
                ptr_q <= sh_q;
              end else begin
                acc_o <= '{we: 1'b1, addr: ptr_q, wdata: sh_q};
                req_t_o <= ~req_t_o;
                ptr_q <= ptr_q + 1'b1;
              end
            end
          end
          S_ACK: begin
            if (fall) begin
              state_q <= nxt_q;
              cnt_q <= 4'h0;
              sda_oe <= 1'b0;
              if (nxt_q == S_RD) begin
                sh_q <= rbuf_q;
                sda_oe <= ~rbuf_q[7];
                cnt_q <= 4'h1;
                ptr_q <= ptr_q + 1'b1;
              end
            end
          end
          S_RD: begin
            if (byte_end) begin
              sda_oe <= 1'b0;
              state_q <= S_RACK;
            end else if (fall) begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
              cnt_q <= cnt_q + 1'b1;
            end
          end
          S_RACK: begin
            if (rise && sda_s) begin
              state_q <= S_IDLE;
            end else if (rise) begin
              acc_o <= '{we: 1'b0, addr: ptr_q, wdata: 8'h00};
              req_t_o <= ~req_t_o;
              nxt_q <= S_RD;
              state_q <= S_ACK;
            end
          end
        endcase
      end
    end
  end

  // Deselected module leaves the data line alone
  chk_desel_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !sel |=> !sda_oe)
    else $error("data driven while deselected");
endmodule
`default_nettype wire

// ==== tb/omt_host.sv ====
/*
  Host controller model: bit-banged two-wire bus master.
  Assumes an open-drain data wire with a pull-up, paced by the ref clock.
*/
`timescale 1ns/1ps
`default_nettype none
module omt_host (
  input wire logic clk, // Pacing clock
  input wire logic dev_oe, // Device pulls data low
  output logic scl, // Bus clock
  output logic sda // Resolved data wire
);
  logic oe = 1'b0; // Host pulls data low
  initial scl = 1'b1;
  // Released wire floats to the pull-up
  assign sda = ~(oe | dev_oe);
  // Third of a bit, far above the slave's minimum
  task automatic hb();
    repeat (25) @(posedge clk);
    #1;
  endtask
  // Start or repeated start
  task automatic start();
    oe = 1'b0;
    hb();
    scl = 1'b1;
    hb();
    oe = 1'b1;
    hb();
    scl = 1'b0;
  endtask
  task automatic stop();
    hb();
    oe = 1'b1;
    hb();
    scl = 1'b1;
    hb();
    oe = 1'b0;
    hb();
  endtask
  // One bit out, wire sampled before the clock falls
  task automatic bitx(input logic b, output logic r);
    hb();
    oe = ~b;
    hb();
    scl = 1'b1;
    hb();
    r = sda;
    scl = 1'b0;
  endtask
  // Byte MSB first, ninth bit released for acknowledge
  task automatic xfer(input logic [7:0] v, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(v[i], r[i]);
    bitx(1'b1, a);
    ack = ~a;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a1, a2, a3;
    start();
    xfer(ad, r, a1);
    xfer(p, r, a2);
    xfer(d, r, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask
  // Pointer write, repeated start, one byte then no-ack
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    xfer(8'hA0, r, a);
    xfer(p, r, a);
    start();
    xfer(8'hA1, r, a);
    xfer(8'hFF, d, a);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the module management block.
  Assumes shortened init and tx squelch counts; host model drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import omt_pkg::*;;
  localparam int unsigned INIT_P = 200; // Shortened start-up
  localparam int unsigned TXSQ_P = 50; // Shortened tx squelch
  logic ref_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, sel_n = 1'b0, rst_in_n = 1'b1, lp = 1'b0;
  logic [3:0] rx_los = 4'h0, tx_los = 4'h0, tx_flt = 4'h0, tx_en, rx_en;
  logic scl, sda, sda_o, irq_o, irq_oe, pwr_low, ready, sda_oe, ok;
  int fail_count = 0, num_checks = 0, cycles = 0;
  wire irq_n = ~irq_oe; // Pulled-up interrupt wire
  omt_top #(.INIT_CYC_P(INIT_P), .TXSQ_CYC_P(TXSQ_P)) u_omt_top (.REF_CLK(ref_clk), .RESETN(resetn),
    .LINK_CLK(link_clk), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .MODULE_SELECT_N(sel_n),
    .RESET_IN_N(rst_in_n), .LOW_POWER_PIN(lp), .RX_LOS_IN(rx_los), .TX_LOS_IN(tx_los), .TX_FAULT_IN(tx_flt),
    .INTERRUPT_OUT_O(irq_o), .INTERRUPT_OUT_OE(irq_oe), .POWER_LOW(pwr_low), .MOD_READY(ready),
    .TX_EN(tx_en), .RX_EN(rx_en));
  omt_host u_omt_host (.clk(ref_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  initial forever #20 ref_clk = ~ref_clk;
  // Link clock, phase unrelated
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] d);
    u_omt_host.wr(8'hA0, p, d, ok);
    chk("ack", 8'h01, 8'(ok));
  endtask
  task automatic rc(input string nm, input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] v;
    u_omt_host.rd(p, v);
    chk(nm, exp, v);
  endtask
  task automatic t_init();
    cyc(INIT_P - 5);
    chk("early ready", 8'h00, 8'(ready));
    cyc(10);
    chk("ready", 8'h01, 8'(ready));
    chk("done irq", 8'h00, 8'(irq_n));
    chk("od low", 8'h00, {6'h00, sda_o, irq_o});
    rc("status", A_STATUS, 8'h00);
    cyc(5);
    chk("irq off", 8'h01, 8'(irq_n));
  endtask
  task automatic t_power();
    lp = 1'b1;
    cyc(10);
    chk("lp pin", 8'h01, 8'(pwr_low));
    lp = 1'b0;
    w(A_PWR, 8'h02);
    cyc(10);
    chk("pdown", 8'h01, 8'(pwr_low));
    w(A_PWR, 8'h00);
    cyc(10);
    chk("pup", 8'h00, 8'(pwr_low));
  endtask
  task automatic t_rxlos();
    rx_los = 4'h4;
    cyc(10);
    chk("los irq", 8'h00, 8'(irq_n));
    cyc(2000);
    chk("rx sq", 8'h0B, 8'(rx_en));
    rx_los = 4'h0;
    cyc(2000);
    chk("rx unsq", 8'h0F, 8'(rx_en));
    rc("los", A_LOS, 8'h04);
    cyc(20);
    chk("los off", 8'h01, 8'(irq_n));
    rc("los clr", A_LOS, 8'h00);
  endtask
  task automatic t_mask();
    w(A_MASK_LOS, 8'h01);
    rx_los = 4'h1;
    cyc(10);
    chk("masked", 8'h01, 8'(irq_n));
    w(A_MASK_LOS, 8'h00);
    cyc(10);
    chk("unmasked", 8'h00, 8'(irq_n));
    rx_los = 4'h0;
    rc("lane0", A_LOS, 8'h01);
  endtask
  task automatic t_tx();
    tx_flt = 4'h2;
    cyc(10);
    chk("flt irq", 8'h00, 8'(irq_n));
    chk("flt off", 8'h0D, 8'(tx_en));
    tx_flt = 4'h0;
    rc("fault", A_FAULT, 8'h02);
    w(A_TXDIS, 8'h03);
    cyc(10);
    chk("txdis", 8'h0C, 8'(tx_en));
    w(A_TXDIS, 8'h00);
    cyc(10);
    chk("txen", 8'h0F, 8'(tx_en));
    tx_los = 4'h8;
    cyc(TXSQ_P + 10);
    chk("tx sq", 8'h07, 8'(tx_en));
    chk("txlos irq", 8'h00, 8'(irq_n));
    tx_los = 4'h0;
    cyc(TXSQ_P + 10);
    chk("tx unsq", 8'h0F, 8'(tx_en));
    rc("txlos", A_LOS, 8'h80);
  endtask
  task automatic t_page();
    w(A_PAGE, 8'h01);
    w(8'h80, 8'h5A);
    w(A_PAGE, 8'h02);
    w(8'h80, 8'hA5);
    w(A_PAGE, 8'h01);
    rc("page", 8'h80, 8'h5A);
    w(A_PAGE, CTL_PAGE);
    w(A_RXDIS, 8'h10);
    cyc(10);
    chk("rxdis", 8'h0E, 8'(rx_en));
    w(A_RXDIS, 8'h00);
    w(A_SQDIS, 8'h10);
    rx_los = 4'h1;
    cyc(2100);
    chk("sqdis", 8'h0F, 8'(rx_en));
    rx_los = 4'h0;
  endtask
  task automatic t_bus();
    u_omt_host.wr(8'hA2, A_TXDIS, 8'h0F, ok);
    chk("bad addr", 8'h00, 8'(ok));
    sel_n = 1'b1;
    cyc(10);
    u_omt_host.wr(8'hA0, A_TXDIS, 8'h0F, ok);
    chk("desel", 8'h00, 8'(ok));
    chk("desel tx", 8'h0F, 8'(tx_en));
    sel_n = 1'b0;
    cyc(10);
  endtask
  task automatic t_reset();
    rst_in_n = 1'b0;
    cyc(20);
    rst_in_n = 1'b1;
    cyc(10);
    chk("short rst", 8'h01, 8'(ready));
    rst_in_n = 1'b0;
    cyc(70);
    chk("long rst", 8'h00, 8'(ready));
    rst_in_n = 1'b1;
    cyc(INIT_P + 10);
    chk("rst ready", 8'h01, 8'(ready));
    chk("rst irq", 8'h00, 8'(irq_n));
  endtask
  initial begin
    cyc(6);
    resetn = 1'b1;
    t_init();
    t_power();
    t_rxlos();
    t_mask();
    t_tx();
    t_page();
    t_bus();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
